/* pkg/dpsf_pkg.sv */
// dpsf_pkg: constants and types for the semaphore flag host controller.
// assumes a 40 MHz system clock and one port of the dual-port flag latches outside.
package dpsf_pkg;
	localparam int          CLK_NS     = 25;
	localparam int          N_FLAGS    = 8;
	localparam int          IDX_W      = 3;
	localparam int          ADDR_W     = 16;
	localparam int          DATA_W     = 8;
	localparam int          CNT_W      = 3;
	// strobe timings in ns; least times, so counts round up
	localparam int          T_WR_NS    = 20;
	localparam int          T_GAP_NS   = 25;
	localparam int          T_ACC_NS   = 35;
	localparam int          WR_CYC     = ((T_WR_NS + CLK_NS - 1) / CLK_NS < 1) ? 1 :
	                                     (T_WR_NS + CLK_NS - 1) / CLK_NS;
	localparam int          GAP_CYC    = ((T_GAP_NS + CLK_NS - 1) / CLK_NS < 1) ? 1 :
	                                     (T_GAP_NS + CLK_NS - 1) / CLK_NS;
	localparam int          RD_CYC     = ((T_ACC_NS + CLK_NS - 1) / CLK_NS < 1) ? 1 :
	                                     (T_ACC_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [CNT_W-1:0] WR_LAST  = CNT_W'(WR_CYC - 1);
	localparam logic [CNT_W-1:0] GAP_LAST = CNT_W'(GAP_CYC - 1);
	localparam logic [CNT_W-1:0] RD_LAST  = CNT_W'(RD_CYC - 1);
	localparam logic [CNT_W-1:0] CNT_ZERO = 3'h0;
	localparam logic [CNT_W-1:0] CNT_ONE  = 3'h1;
	localparam logic [IDX_W-1:0] IDX_ZERO = 3'h0;
	localparam logic [IDX_W-1:0] IDX_ONE  = 3'h1;
	localparam logic [IDX_W-1:0] IDX_LAST = 3'h7;
	localparam logic [N_FLAGS-1:0] FLAGS_NONE = 8'h00;
	localparam logic [DATA_W-1:0]  DATA_ZERO  = 8'h00;
	localparam logic [ADDR_W-IDX_W-1:0] ADDR_HI = 13'h0000;
	localparam logic        FLAG_TAKE  = 1'b0;
	localparam logic        FLAG_FREE  = 1'b1;

	typedef enum logic [1:0] {
		OP_CLAIM   = 2'h0,
		OP_RELEASE = 2'h1,
		OP_TEST    = 2'h2,
		OP_INIT    = 2'h3
	} dpsf_op_e;

	typedef enum logic [4:0] {
		ST_IDLE = 5'b00001,
		ST_WR   = 5'b00010,
		ST_GAP  = 5'b00100,
		ST_RD   = 5'b01000,
		ST_FIN  = 5'b10000
	} dpsf_state_e;
endpackage : dpsf_pkg

/* src/dpsf_host_ctrl.sv */
// dpsf_host_ctrl: drives one port of the dual-port semaphore flags.
// assumes the flag pins are sampled synchronously to i_clk and the data bus
// is resolved outside from o_data_oe.
`timescale 1ns/1ps
`default_nettype none
module dpsf_host_ctrl (
	input  wire logic                          i_clk,
	input  wire logic                          i_rst_n,
	input  wire logic                          i_cmd_valid,
	input  wire dpsf_pkg::dpsf_op_e            i_cmd_op,
	input  wire logic [dpsf_pkg::IDX_W-1:0]    i_cmd_idx,
	output logic                               o_cmd_ready,
	output logic                               o_done,
	output logic                               o_granted,
	output logic [dpsf_pkg::N_FLAGS-1:0]       o_owned,
	output logic [dpsf_pkg::N_FLAGS-1:0]       o_pending,
	output logic                               o_ce_n,
	output logic                               o_flag_space_select_n,
	output logic                               o_rw_n,
	output logic                               o_oe_n,
	output logic [dpsf_pkg::ADDR_W-1:0]        o_addr,
	output logic [dpsf_pkg::DATA_W-1:0]        o_data_out,
	output logic                               o_data_oe,
	input  wire logic [dpsf_pkg::DATA_W-1:0]   i_data_in
);
	import dpsf_pkg::*;

	dpsf_state_e          state_r,    state_nxt;
	dpsf_op_e             op_r,       op_nxt;
	logic [IDX_W-1:0]     idx_r,      idx_nxt;
	logic [CNT_W-1:0]     cnt_r,      cnt_nxt;
	logic                 init_act_r, init_act_nxt;
	logic                 granted_r,  granted_nxt;
	logic                 done_r,     done_nxt;
	logic [N_FLAGS-1:0]   owned_r,    owned_nxt;
	logic [N_FLAGS-1:0]   pending_r,  pending_nxt;
	logic                 wr_bit;
	logic                 rd_low;

	////////////////////////////////////////////////////////////////////////////
	// sequencer

	// a read shows the flag on all bits; any low bit counts as taken, so a
	// torn bus with a single low bit reads as a grant
	assign rd_low = ~&i_data_in;
	assign wr_bit = (op_r == OP_CLAIM) ? FLAG_TAKE : FLAG_FREE;

	always_comb begin
		state_nxt    = state_r;
		op_nxt       = op_r;
		idx_nxt      = idx_r;
		cnt_nxt      = cnt_r;
		init_act_nxt = init_act_r;
		granted_nxt  = granted_r;
		done_nxt     = 1'b0;
		owned_nxt    = owned_r;
		pending_nxt  = pending_r;
		unique case (state_r)
			ST_IDLE: begin
				cnt_nxt = CNT_ZERO;
				if (init_act_r) begin
					// start-up clear: release each flag in turn
					op_nxt    = OP_RELEASE;
					state_nxt = ST_WR;
				end else if (i_cmd_valid) begin
					op_nxt  = i_cmd_op;
					idx_nxt = i_cmd_idx;
					if (i_cmd_op == OP_INIT) begin
						init_act_nxt = 1'b1;
						idx_nxt      = IDX_ZERO;
					end else if (i_cmd_op == OP_TEST) begin
						state_nxt = ST_RD;
					end else begin
						// claims always write before any read
						state_nxt = ST_WR;
					end
				end
			end
			ST_WR: begin
				cnt_nxt = cnt_r + CNT_ONE;
				if (cnt_r == WR_LAST) begin
					cnt_nxt   = CNT_ZERO;
					state_nxt = (op_r == OP_CLAIM) ? ST_GAP : ST_FIN;
				end
			end
			ST_GAP: begin
				cnt_nxt = cnt_r + CNT_ONE;
				if (cnt_r == GAP_LAST) begin
					cnt_nxt   = CNT_ZERO;
					state_nxt = ST_RD;
				end
			end
			ST_RD: begin
				cnt_nxt = cnt_r + CNT_ONE;
				if (cnt_r == RD_LAST) begin
					// the device latched its value when select and enable fell,
					// so sampling late in the strobe is safe
					cnt_nxt     = CNT_ZERO;
					granted_nxt = rd_low;
					state_nxt   = ST_FIN;
					if (rd_low) begin
						owned_nxt[idx_r]   = 1'b1;
						pending_nxt[idx_r] = 1'b0;
					end else if (op_r == OP_CLAIM) begin
						// the zero sits in our request latch until withdrawn
						pending_nxt[idx_r] = 1'b1;
						owned_nxt[idx_r]   = 1'b0;
					end
				end
			end
			ST_FIN: begin
				// one cycle with select high ends every access
				state_nxt = ST_IDLE;
				if (op_r == OP_RELEASE) begin
					owned_nxt[idx_r]   = 1'b0;
					pending_nxt[idx_r] = 1'b0;
					granted_nxt        = 1'b0;
				end
				if (init_act_r) begin
					if (idx_r == IDX_LAST) begin
						init_act_nxt = 1'b0;
						done_nxt     = 1'b1;
					end else begin
						idx_nxt = idx_r + IDX_ONE;
					end
				end else begin
					done_nxt = 1'b1;
				end
			end
			default: begin
				state_nxt = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			state_r    <= ST_IDLE;
			op_r       <= OP_RELEASE;
			idx_r      <= IDX_ZERO;
			cnt_r      <= CNT_ZERO;
			init_act_r <= 1'b1;
			granted_r  <= 1'b0;
			done_r     <= 1'b0;
			owned_r    <= FLAGS_NONE;
			pending_r  <= FLAGS_NONE;
		end else begin
			state_r    <= state_nxt;
			op_r       <= op_nxt;
			idx_r      <= idx_nxt;
			cnt_r      <= cnt_nxt;
			init_act_r <= init_act_nxt;
			granted_r  <= granted_nxt;
			done_r     <= done_nxt;
			owned_r    <= owned_nxt;
			pending_r  <= pending_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// pins

	// memory enable is never asserted: this block only touches flag space
	assign o_ce_n                = 1'b1;
	assign o_flag_space_select_n = !((state_r == ST_WR) || (state_r == ST_RD));
	assign o_rw_n                = (state_r != ST_WR);
	assign o_oe_n                = (state_r != ST_RD);
	// upper lines are don't-care in flag space; driven low for a quiet bus
	assign o_addr                = {ADDR_HI, idx_r};
	assign o_data_out            = {{(DATA_W-1){1'b0}}, wr_bit};
	assign o_data_oe             = (state_r == ST_WR);
	assign o_cmd_ready           = (state_r == ST_IDLE) && !init_act_r;
	assign o_done                = done_r;
	assign o_granted             = granted_r;
	assign o_owned               = owned_r;
	assign o_pending             = pending_r;

	////////////////////////////////////////////////////////////////////////////
	// checks

	sequence claim_wr_end_s;
		(state_r == ST_WR) && (op_r == OP_CLAIM) && (cnt_r == WR_LAST);
	endsequence

	sequence gap_then_read_s;
		o_flag_space_select_n ##1 (!o_flag_space_select_n && !o_oe_n);
	endsequence

	sel_no_mem_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		!o_flag_space_select_n |-> o_ce_n)
		else $error("memory enable active during flag access");

	read_release_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		((state_r == ST_RD) && (cnt_r == RD_LAST)) |=> (o_flag_space_select_n && o_oe_n))
		else $error("select not dropped after flag read");

	write_then_read_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		claim_wr_end_s |=> gap_then_read_s)
		else $error("claim write not followed by gap and read back");

	claim_starts_write_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(o_cmd_ready && i_cmd_valid && (i_cmd_op == OP_CLAIM)) |=> !o_rw_n [*1] ##0 o_oe_n)
		else $error("claim did not begin with a write");

	claim_data_zero_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(!o_rw_n && (op_r == OP_CLAIM)) |-> (o_data_oe && (o_data_out[0] == FLAG_TAKE)))
		else $error("claim write did not drive zero");

	fail_pending_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		((state_r == ST_RD) && (cnt_r == RD_LAST) && (op_r == OP_CLAIM) && !rd_low)
		|=> (pending_r[idx_r] && !granted_r))
		else $error("failed claim not tracked as pending");

	init_ones_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(init_act_r && !o_rw_n) |-> (o_data_out[0] == FLAG_FREE))
		else $error("start-up write not a one");

	init_all_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		$fell(init_act_r) |-> ($past(idx_r) == IDX_LAST) && o_done)
		else $error("start-up ended before the last flag");
endmodule : dpsf_host_ctrl
`default_nettype wire

/* tb/dpsf_flag_model.sv */
// dpsf_flag_model: eight semaphore flag latches shared by two ports.
// assumes both ports strobe synchronously to i_clk; bench is the far port.
`timescale 1ns/1ps
`default_nettype none
module dpsf_flag_model (
	input  wire logic        i_clk,
	input  wire logic        i_l_sel_n,
	input  wire logic        i_l_ce_n,
	input  wire logic        i_l_rw_n,
	input  wire logic        i_l_oe_n,
	input  wire logic [15:0] i_l_addr,
	input  wire logic [7:0]  i_l_din,
	output logic      [7:0]  o_l_q = 8'h00,
	input  wire logic        i_r_sel_n,
	input  wire logic        i_r_rw_n,
	input  wire logic [2:0]  i_r_idx,
	input  wire logic        i_r_d0,
	output logic             o_r_view
);
	// no power-up clear: junk state, left owns with both requests low
	logic [7:0] req_l = 8'h00;
	logic [7:0] req_r = 8'h00;
	logic [1:0] own [8] = '{default: 2'h1};
	logic       rd_on = 1'b0;
	assign o_r_view = (own[i_r_idx] != 2'h2);
	always @(posedge i_clk) begin
		if (!i_l_sel_n && !i_l_rw_n && i_l_ce_n)
			req_l[i_l_addr[2:0]] = i_l_din[0];
		if (!i_r_sel_n && !i_r_rw_n)
			req_r[i_r_idx] = i_r_d0;
		for (int i = 0; i < 8; i++) begin
			// only the owner frees; a pending request takes over
			if ((own[i] == 2'h1 && req_l[i]) || (own[i] == 2'h2 && req_r[i]))
				own[i] = 2'h0;
			// same-edge tie goes to the left port
			if (own[i] == 2'h0)
				own[i] = !req_l[i] ? 2'h1 : (!req_r[i] ? 2'h2 : 2'h0);
		end
		if (!i_l_sel_n && !i_l_oe_n && i_l_ce_n) begin
			// read data leaves by non-blocking update so the controller samples a settled bus
			if (!rd_on)
				o_l_q <= {8{own[i_l_addr[2:0]] != 2'h1}};
			rd_on = 1'b1;
		end else begin
			// released bus moves every cycle so a stale value never passes
			rd_on = 1'b0;
			o_l_q <= ~o_l_q;
		end
	end
endmodule : dpsf_flag_model
`default_nettype wire

/* tb/dpsf_host_ctrl_bench.sv */
// dpsf_host_ctrl_bench: host controller against the flag model.
// assumes the bench plays the far processor on the model's right port.
`timescale 1ns/1ps
`default_nettype none
module dpsf_host_ctrl_bench;
	import dpsf_pkg::*;
	logic        i_clk = 1'b0, i_rst_n = 1'b0, i_cmd_valid = 1'b0;
	dpsf_op_e    i_cmd_op = OP_TEST, cur_op = OP_INIT;
	logic [2:0]  i_cmd_idx = 3'h0, cur_idx = 3'h0, r_idx = 3'h0, k;
	logic        o_cmd_ready, o_done, o_granted, o_ce_n, o_sel_n, o_rw_n, o_oe_n, o_data_oe;
	logic [7:0]  o_owned, o_pending, o_data_out, l_q, bus;
	logic [15:0] o_addr;
	logic        r_sel_n = 1'b1, r_rw_n = 1'b1, r_d0 = 1'b1, r_view;
	int          n_errors = 0, checks_done = 0;
	logic [6:0]  exp_q [$]; // {granted matters, idx, granted, owned, pending}
	logic [6:0]  e;
	assign bus = o_data_oe ? o_data_out : l_q;
	dpsf_host_ctrl DUT (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_cmd_valid(i_cmd_valid),
		.i_cmd_op(i_cmd_op), .i_cmd_idx(i_cmd_idx), .o_cmd_ready(o_cmd_ready),
		.o_done(o_done), .o_granted(o_granted), .o_owned(o_owned), .o_pending(o_pending),
		.o_ce_n(o_ce_n), .o_flag_space_select_n(o_sel_n), .o_rw_n(o_rw_n),
		.o_oe_n(o_oe_n), .o_addr(o_addr), .o_data_out(o_data_out),
		.o_data_oe(o_data_oe), .i_data_in(bus));
	dpsf_flag_model MDL (.i_clk(i_clk), .i_l_sel_n(o_sel_n), .i_l_ce_n(o_ce_n),
		.i_l_rw_n(o_rw_n), .i_l_oe_n(o_oe_n), .i_l_addr(o_addr), .i_l_din(bus),
		.o_l_q(l_q), .i_r_sel_n(r_sel_n), .i_r_rw_n(r_rw_n), .i_r_idx(r_idx),
		.i_r_d0(r_d0), .o_r_view(r_view));
	initial forever #12.5 i_clk = ~i_clk;
	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(string nm, logic [15:0] x, logic [15:0] g);
		checks_done++;
		if (g !== x) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", nm, x, g);
		end
	endtask : chk
	task automatic stop_test();
		$display("checks %0d mismatches %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : stop_test
	// x = {granted matters, granted, owned, pending} after the command
	task automatic cmd(dpsf_op_e op, logic [2:0] i, logic [3:0] x);
		@(posedge i_clk);
		i_cmd_valid <= 1'b1;
		i_cmd_op <= op;
		i_cmd_idx <= i;
		cur_op <= op;
		cur_idx <= i;
		exp_q.push_back({x[3], i, x[2:0]});
		do @(posedge i_clk); while (o_cmd_ready !== 1'b1);
		i_cmd_valid <= 1'b0;
		for (int t = 0; t < 40 && o_done !== 1'b1; t++) @(posedge i_clk);
		chk("done", 16'h1, 16'(o_done));
	endtask : cmd
	task automatic rwr(logic [2:0] i, logic v);
		@(posedge i_clk);
		r_sel_n <= 1'b0;
		r_rw_n <= 1'b0;
		r_idx <= i;
		r_d0 <= v;
		@(posedge i_clk);
		r_sel_n <= 1'b1;
		r_rw_n <= 1'b1;
		// let the latch settle before anyone looks at the far view
		@(posedge i_clk);
	endtask : rwr
	////////////////////////////////////////////////////////////////////////////////
	always @(posedge i_clk) begin
		if (o_sel_n === 1'b0) begin
			chk("ce_n", 16'h1, 16'(o_ce_n));
			if (cur_op != OP_INIT) chk("addr", 16'(cur_idx), o_addr);
			else chk("addr_hi", 16'h0, 16'(o_addr[15:3]));
			if (o_rw_n === 1'b0) chk("wr_bit", 16'(cur_op != OP_CLAIM), 16'(o_data_out[0]));
			chk("oe_n", 16'(!o_rw_n), 16'(o_oe_n));
			chk("data_oe", 16'(!o_rw_n), 16'(o_data_oe));
		end else if (i_rst_n === 1'b1) begin
			chk("idle_pins", 16'h6, 16'({o_oe_n, o_rw_n, o_data_oe}));
		end
		if (o_done === 1'b1 && exp_q.size() > 0) begin
			e = exp_q.pop_front();
			chk("ready", 16'h1, 16'(o_cmd_ready));
			if (e[6]) chk("granted", 16'(e[2]), 16'(o_granted));
			chk("owned", 16'(e[1]), 16'(o_owned[e[5:3]]));
			chk("pending", 16'(e[0]), 16'(o_pending[e[5:3]]));
		end
	end
	initial begin
		repeat (5000) @(posedge i_clk);
		n_errors++;
		stop_test();
	end
	initial begin
		void'($urandom(32'hfaf9));
		k = 3'($urandom());
		exp_q.push_back(7'h00); // start-up clear leaves nothing owned
		repeat (10) @(posedge i_clk);
		i_rst_n <= 1'b1;
		for (int t = 0; t < 60 && o_done !== 1'b1; t++) @(posedge i_clk);
		chk("startup_done", 16'h1, 16'(o_done));
		for (int i = 0; i < 8; i++) rwr(3'(i), 1'b1); // far side frees its latches
		$display("test startup done");
		cmd(OP_CLAIM, k, 4'b1110);
		rwr(k, 1'b0);
		chk("far_view", 16'h1, 16'(r_view));
		cmd(OP_RELEASE, k, 4'b1000);
		chk("far_view", 16'h0, 16'(r_view));
		cmd(OP_TEST, k, 4'b1000);
		cmd(OP_CLAIM, k, 4'b1001);
		cmd(OP_TEST, k, 4'b1001);
		rwr(k, 1'b1);
		cmd(OP_TEST, k, 4'b1110);
		cmd(OP_RELEASE, k, 4'b1000);
		$display("test handover done");
		fork
			cmd(OP_CLAIM, k, 4'b1001);
			rwr(k, 1'b0);
		join
		cmd(OP_RELEASE, k, 4'b1000);
		rwr(k, 1'b1);
		cmd(OP_TEST, k, 4'b1000);
		$display("test contention done");
		for (int i = 0; i < 8; i++) cmd(OP_CLAIM, 3'(i), 4'b1110);
		cmd(OP_INIT, k, 4'b0000);
		rwr(k, 1'b0);
		chk("far_view", 16'h0, 16'(r_view));
		$display("test init done");
		stop_test();
	end
endmodule : dpsf_host_ctrl_bench
`default_nettype wire
